// ### hw/nss_consts.vh
// Constants for the network sync supervision block: selector codes,
// reset values, cycle encodings and field positions.
// Assumes inclusion by bare name from files under hw/.
//
// Functional notes
// - Decode cycle codes 04..0A to 125us..8ms
// - Code zero loads 250000 ns automatically
// - Unsupported cycle code raises parameter error alarm
// - Configured cycle seeds both cycle time objects
// - Missed update at sync adds three
// - Good update at sync subtracts one
// - Counter reaching threshold raises receive alarm
// - Threshold zero disables receive error detection
// - After alarm, counter holds at threshold
// - Threshold and limit object share storage
// - Warning mask gates active and latched warnings
// - Error mask gates errors, shared with object
// - Attribute select picks new or legacy mapping
`ifndef NSS_CONSTS_VH
`define NSS_CONSTS_VH

// ----------------------------------------------------------------
// Register selector codes on the parameter/object access port
// ----------------------------------------------------------------
`define NSS_SEL_MODE_WORD 4'h0
`define NSS_SEL_CYCLE_INIT 4'h1
`define NSS_SEL_SYNC_THR 4'h2
`define NSS_SEL_WARN_MASK 4'h3
`define NSS_SEL_ERR_MASK 4'h4
`define NSS_SEL_OUT_CYCLE_OBJ 4'h5
`define NSS_SEL_IN_CYCLE_OBJ 4'h6
`define NSS_SEL_LIMIT_OBJ 4'h7
`define NSS_SEL_WARN_MASK_OBJ 4'h8
`define NSS_SEL_ERR_MASK_OBJ 4'h9
`define NSS_SEL_ERR_COUNT 4'hA

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define NSS_RST_MODE_WORD 32'h00000000
`define NSS_RST_CYCLE_INIT 32'h00000000
`define NSS_RST_SYNC_THR 16'h0009
`define NSS_RST_MASK 32'h0FFFFFFF
`define NSS_THR_VALID_MASK 16'h7FFF

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define NSS_ATTR_SEL_BIT 12
`define NSS_CYCLE_CODE_MSB 7

// ----------------------------------------------------------------
// Cycle codes and their periods in nanoseconds
// ----------------------------------------------------------------
`define NSS_CODE_AUTO 8'h00
`define NSS_CODE_125US 8'h04
`define NSS_CODE_250US 8'h05
`define NSS_CODE_500US 8'h06
`define NSS_CODE_1MS 8'h07
`define NSS_CODE_2MS 8'h08
`define NSS_CODE_4MS 8'h09
`define NSS_CODE_8MS 8'h0A
`define NSS_NS_125US 32'd125000
`define NSS_NS_250US 32'd250000
`define NSS_NS_500US 32'd500000
`define NSS_NS_1MS 32'd1000000
`define NSS_NS_2MS 32'd2000000
`define NSS_NS_4MS 32'd4000000
`define NSS_NS_8MS 32'd8000000
`define NSS_NS_AUTO 32'd250000

// ----------------------------------------------------------------
// Sync error counter weights
// ----------------------------------------------------------------
`define NSS_MISS_WEIGHT 17'd3
`define NSS_GOOD_WEIGHT 16'd1

// ----------------------------------------------------------------
// Mapping permission masks, bit order: max torque, home offset,
// max motor speed, encoder increments, motor revolutions
// ----------------------------------------------------------------
`define NSS_MAP_NEW_RX 5'h1F
`define NSS_MAP_NEW_TX 5'h00
`define NSS_MAP_OLD_RX 5'h01
`define NSS_MAP_OLD_TX 5'h1F

`endif

// ### hw/nss_err_cnt.v
// Weighted sync error counter with threshold alarm.
// Assumes one clock; sync_evt_in is a one-cycle pulse and
// pdo_upd_in is valid in the same cycle.
`timescale 1ns/1ps
`include "nss_consts.vh"

module nss_err_cnt (
  input wire clk_in,
  input wire rst_b_in,
  input wire sync_evt_in,
  input wire pdo_upd_in,
  input wire [15:0] thr_in,
  input wire clr_in,
  output reg [15:0] count_out,
  output reg alarm_out
);

  reg [16:0] sum_nxt;
  reg [15:0] base_cnt;
  reg [15:0] count_nxt;
  reg alarm_nxt;

  // ----------------------------------------------------------------
  // Next count and alarm
  // ----------------------------------------------------------------
  // One bit of headroom in the sum so a large add cannot wrap past thr
  always @* begin
    base_cnt = clr_in ? 16'h0000 : count_out;
    sum_nxt = {1'b0, base_cnt} + `NSS_MISS_WEIGHT;
    count_nxt = count_out;
    alarm_nxt = alarm_out;
    if (thr_in == 16'h0000) begin
      count_nxt = 16'h0000;
      alarm_nxt = 1'b0;
    end else if (clr_in) begin
      count_nxt = 16'h0000;
      alarm_nxt = 1'b0;
      // A miss in the clearing cycle still counts: set beats clear
      if (sync_evt_in && !pdo_upd_in) begin
        if (sum_nxt >= {1'b0, thr_in}) begin
          count_nxt = thr_in;
          alarm_nxt = 1'b1;
        end else begin
          count_nxt = sum_nxt[15:0];
        end
      end
    end else if (sync_evt_in) begin
      if (alarm_out) begin
        count_nxt = thr_in;
      end else if (!pdo_upd_in) begin
        if (sum_nxt >= {1'b0, thr_in}) begin
          count_nxt = thr_in;
          alarm_nxt = 1'b1;
        end else begin
          count_nxt = sum_nxt[15:0];
        end
      end else if (count_out != 16'h0000) begin
        count_nxt = count_out - `NSS_GOOD_WEIGHT;
      end else begin
        count_nxt = 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= 16'h0000;
      alarm_out <= 1'b0;
    end else begin
      count_out <= count_nxt;
      alarm_out <= alarm_nxt;
    end
  end

endmodule

// ### hw/nss_top.v
// Network configuration and supervision: initial cycle selection,
// sync error supervision, mapping attribute select and detail masks.
// Assumes all inputs synchronous to CLK_IN; parameter and object
// writes arrive as single-cycle strobes with a selector code.
`timescale 1ns/1ps
`include "nss_consts.vh"

module nss_top (
  input wire CLK_IN,
  input wire RST_B_IN,
  input wire PARAM_WR_IN,
  input wire [3:0] PARAM_SEL_IN,
  input wire [31:0] PARAM_WDATA_IN,
  output reg [31:0] PARAM_RDATA_OUT,
  input wire SYNC_EVENT_IN,
  input wire PDO_UPDATED_IN,
  input wire ALARM_CLEAR_IN,
  input wire [31:0] WARN_ACTIVE_IN,
  input wire [31:0] WARN_LATCHED_IN,
  input wire [31:0] ERR_ACTIVE_IN,
  input wire [31:0] ERR_LATCHED_IN,
  output reg [31:0] WARN_ACTIVE_OUT,
  output reg [31:0] WARN_LATCHED_OUT,
  output reg [31:0] ERR_ACTIVE_OUT,
  output reg [31:0] ERR_LATCHED_OUT,
  output reg [31:0] OUT_CYCLE_TIME_OUT,
  output reg [31:0] IN_CYCLE_TIME_OUT,
  output reg PARAM_ERROR_ALARM_OUT,
  output wire NET_RX_DATA_ALARM_OUT,
  output wire [15:0] SYNC_ERR_COUNT_OUT,
  output reg [4:0] RX_MAP_ALLOW_OUT,
  output reg [4:0] TX_MAP_ALLOW_OUT
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Period for a cycle code; zero marks an unsupported code
  function [31:0] cycle_ns;
    input [7:0] code;
    begin
      case (code)
        `NSS_CODE_AUTO: cycle_ns = `NSS_NS_AUTO;
        `NSS_CODE_125US: cycle_ns = `NSS_NS_125US;
        `NSS_CODE_250US: cycle_ns = `NSS_NS_250US;
        `NSS_CODE_500US: cycle_ns = `NSS_NS_500US;
        `NSS_CODE_1MS: cycle_ns = `NSS_NS_1MS;
        `NSS_CODE_2MS: cycle_ns = `NSS_NS_2MS;
        `NSS_CODE_4MS: cycle_ns = `NSS_NS_4MS;
        `NSS_CODE_8MS: cycle_ns = `NSS_NS_8MS;
        default: cycle_ns = 32'h00000000;
      endcase
    end
  endfunction

  // Masked detail word; a cleared mask bit hides that detail
  function [31:0] apply_mask;
    input [31:0] detail;
    input [31:0] mask;
    begin
      apply_mask = detail & mask;
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [31:0] network_mode_word_r;
  reg [31:0] comm_cycle_initial_r;
  reg [15:0] sync_error_limit_r;
  reg [31:0] warning_mask_word_r;
  reg [31:0] error_mask_word_r;
  reg init_load_r;

  wire [7:0] cycle_initial_code;
  wire [31:0] cycle_initial_ns;
  wire object_attribute_select;
  wire [15:0] err_count;
  wire rx_alarm;
  wire wr_mode;
  wire wr_cycle;
  wire wr_thr;
  wire wr_wmask;
  wire wr_emask;
  wire wr_out_obj;
  wire wr_in_obj;
  wire load_cycle;

  assign cycle_initial_code = comm_cycle_initial_r[`NSS_CYCLE_CODE_MSB:0];
  assign cycle_initial_ns = cycle_ns(cycle_initial_code);
  assign object_attribute_select = network_mode_word_r[`NSS_ATTR_SEL_BIT];

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Limit and mask parameter and object selectors alias onto the same storage
  assign wr_mode = PARAM_WR_IN && (PARAM_SEL_IN == `NSS_SEL_MODE_WORD);
  assign wr_cycle = PARAM_WR_IN && (PARAM_SEL_IN == `NSS_SEL_CYCLE_INIT);
  assign wr_thr = PARAM_WR_IN && ((PARAM_SEL_IN == `NSS_SEL_SYNC_THR) ||
                                  (PARAM_SEL_IN == `NSS_SEL_LIMIT_OBJ));
  assign wr_wmask = PARAM_WR_IN && ((PARAM_SEL_IN == `NSS_SEL_WARN_MASK) ||
                                    (PARAM_SEL_IN == `NSS_SEL_WARN_MASK_OBJ));
  assign wr_emask = PARAM_WR_IN && ((PARAM_SEL_IN == `NSS_SEL_ERR_MASK) ||
                                    (PARAM_SEL_IN == `NSS_SEL_ERR_MASK_OBJ));
  assign wr_out_obj = PARAM_WR_IN && (PARAM_SEL_IN == `NSS_SEL_OUT_CYCLE_OBJ);
  assign wr_in_obj = PARAM_WR_IN && (PARAM_SEL_IN == `NSS_SEL_IN_CYCLE_OBJ);

  // Seed objects once after reset and again after every write of a supported setting
  assign load_cycle = init_load_r;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Threshold is kept to 15 bits since its range tops out at 32767
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      network_mode_word_r <= `NSS_RST_MODE_WORD;
      comm_cycle_initial_r <= `NSS_RST_CYCLE_INIT;
      sync_error_limit_r <= `NSS_RST_SYNC_THR;
      warning_mask_word_r <= `NSS_RST_MASK;
      error_mask_word_r <= `NSS_RST_MASK;
      init_load_r <= 1'b1;
    end else begin
      init_load_r <= wr_cycle;
      if (wr_mode) begin
        network_mode_word_r <= PARAM_WDATA_IN;
      end
      if (wr_cycle) begin
        comm_cycle_initial_r <= PARAM_WDATA_IN;
      end
      if (wr_thr) begin
        sync_error_limit_r <= PARAM_WDATA_IN[15:0] & `NSS_THR_VALID_MASK;
      end
      if (wr_wmask) begin
        warning_mask_word_r <= PARAM_WDATA_IN;
      end
      if (wr_emask) begin
        error_mask_word_r <= PARAM_WDATA_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Cycle time objects and parameter error
  // ----------------------------------------------------------------
  // A master may still overwrite the objects; a reload follows reset or
  // a write of a supported initial setting, and wins over a master write in its cycle
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      OUT_CYCLE_TIME_OUT <= `NSS_NS_AUTO;
      IN_CYCLE_TIME_OUT <= `NSS_NS_AUTO;
      PARAM_ERROR_ALARM_OUT <= 1'b0;
    end else begin
      PARAM_ERROR_ALARM_OUT <= (cycle_initial_ns == 32'h00000000);
      if (load_cycle && (cycle_initial_ns != 32'h00000000)) begin
        OUT_CYCLE_TIME_OUT <= cycle_initial_ns;
        IN_CYCLE_TIME_OUT <= cycle_initial_ns;
      end else begin
        if (wr_out_obj) begin
          OUT_CYCLE_TIME_OUT <= PARAM_WDATA_IN;
        end
        if (wr_in_obj) begin
          IN_CYCLE_TIME_OUT <= PARAM_WDATA_IN;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sync error supervision
  // ----------------------------------------------------------------
  nss_err_cnt u_err_cnt (
    .clk_in(CLK_IN),
    .rst_b_in(RST_B_IN),
    .sync_evt_in(SYNC_EVENT_IN),
    .pdo_upd_in(PDO_UPDATED_IN),
    .thr_in(sync_error_limit_r),
    .clr_in(ALARM_CLEAR_IN),
    .count_out(err_count),
    .alarm_out(rx_alarm)
  );

  // Counter module drives these straight from its own flip-flops
  assign NET_RX_DATA_ALARM_OUT = rx_alarm;
  assign SYNC_ERR_COUNT_OUT = err_count;

  // ----------------------------------------------------------------
  // Detail masks and mapping attributes
  // ----------------------------------------------------------------
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      WARN_ACTIVE_OUT <= 32'h00000000;
      WARN_LATCHED_OUT <= 32'h00000000;
      ERR_ACTIVE_OUT <= 32'h00000000;
      ERR_LATCHED_OUT <= 32'h00000000;
      RX_MAP_ALLOW_OUT <= `NSS_MAP_NEW_RX;
      TX_MAP_ALLOW_OUT <= `NSS_MAP_NEW_TX;
    end else begin
      WARN_ACTIVE_OUT <= apply_mask(WARN_ACTIVE_IN, warning_mask_word_r);
      WARN_LATCHED_OUT <= apply_mask(WARN_LATCHED_IN, warning_mask_word_r);
      ERR_ACTIVE_OUT <= apply_mask(ERR_ACTIVE_IN, error_mask_word_r);
      ERR_LATCHED_OUT <= apply_mask(ERR_LATCHED_IN, error_mask_word_r);
      if (object_attribute_select) begin
        RX_MAP_ALLOW_OUT <= `NSS_MAP_OLD_RX;
        TX_MAP_ALLOW_OUT <= `NSS_MAP_OLD_TX;
      end else begin
        RX_MAP_ALLOW_OUT <= `NSS_MAP_NEW_RX;
        TX_MAP_ALLOW_OUT <= `NSS_MAP_NEW_TX;
      end
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  // Read data follows the selector one clock later, writes or not
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      PARAM_RDATA_OUT <= 32'h00000000;
    end else begin
      case (PARAM_SEL_IN)
        `NSS_SEL_MODE_WORD: PARAM_RDATA_OUT <= network_mode_word_r;
        `NSS_SEL_CYCLE_INIT: PARAM_RDATA_OUT <= comm_cycle_initial_r;
        `NSS_SEL_SYNC_THR: PARAM_RDATA_OUT <= {16'h0000, sync_error_limit_r};
        `NSS_SEL_LIMIT_OBJ: PARAM_RDATA_OUT <= {16'h0000, sync_error_limit_r};
        `NSS_SEL_WARN_MASK: PARAM_RDATA_OUT <= warning_mask_word_r;
        `NSS_SEL_WARN_MASK_OBJ: PARAM_RDATA_OUT <= warning_mask_word_r;
        `NSS_SEL_ERR_MASK: PARAM_RDATA_OUT <= error_mask_word_r;
        `NSS_SEL_ERR_MASK_OBJ: PARAM_RDATA_OUT <= error_mask_word_r;
        `NSS_SEL_OUT_CYCLE_OBJ: PARAM_RDATA_OUT <= OUT_CYCLE_TIME_OUT;
        `NSS_SEL_IN_CYCLE_OBJ: PARAM_RDATA_OUT <= IN_CYCLE_TIME_OUT;
        `NSS_SEL_ERR_COUNT: PARAM_RDATA_OUT <= {16'h0000, err_count};
        default: PARAM_RDATA_OUT <= 32'h00000000;
      endcase
    end
  end

endmodule

// ### bench/nss_sync_chk.sv
// Port-level checker for the sync supervision block.
// Assumes it is bound onto nss_top and the constants header is reachable.
`timescale 1ns/1ps
`include "nss_consts.vh"

module nss_sync_chk (
  input wire CLK_IN,
  input wire RST_B_IN,
  input wire PARAM_WR_IN,
  input wire [3:0] PARAM_SEL_IN,
  input wire [31:0] PARAM_WDATA_IN,
  input wire SYNC_EVENT_IN,
  input wire PDO_UPDATED_IN,
  input wire ALARM_CLEAR_IN,
  input wire [31:0] WARN_ACTIVE_IN,
  input wire [31:0] WARN_ACTIVE_OUT,
  input wire [31:0] ERR_LATCHED_IN,
  input wire [31:0] ERR_LATCHED_OUT,
  input wire [31:0] OUT_CYCLE_TIME_OUT,
  input wire [31:0] IN_CYCLE_TIME_OUT,
  input wire PARAM_ERROR_ALARM_OUT,
  input wire NET_RX_DATA_ALARM_OUT,
  input wire [15:0] SYNC_ERR_COUNT_OUT,
  input wire [4:0] RX_MAP_ALLOW_OUT,
  input wire [4:0] TX_MAP_ALLOW_OUT
);
  // ------------------------------------------------------------
  // One clock domain, reset disables everything
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // ------------------------------------------------------------
  // Sync error counter
  // ------------------------------------------------------------
  // Miss adds three unless clamped into the alarm or detection is off
  AST_MISS: assert property (SYNC_EVENT_IN && !PDO_UPDATED_IN && !ALARM_CLEAR_IN && !NET_RX_DATA_ALARM_OUT
    |=> NET_RX_DATA_ALARM_OUT || SYNC_ERR_COUNT_OUT == 16'h0000
    || SYNC_ERR_COUNT_OUT == $past(SYNC_ERR_COUNT_OUT) + 16'h0003) else $error("miss weight wrong");
  AST_GOOD: assert property (SYNC_EVENT_IN && PDO_UPDATED_IN && !ALARM_CLEAR_IN && !NET_RX_DATA_ALARM_OUT
    && !$past(PARAM_WR_IN) && SYNC_ERR_COUNT_OUT != 16'h0000
    |=> SYNC_ERR_COUNT_OUT == $past(SYNC_ERR_COUNT_OUT) - 16'h0001)
    else $error("good update weight wrong");
  AST_FLOOR: assert property (SYNC_EVENT_IN && PDO_UPDATED_IN && SYNC_ERR_COUNT_OUT == 16'h0000
    |=> SYNC_ERR_COUNT_OUT == 16'h0000) else $error("counter went below zero");
  // Held alarm pins the counter, good or bad events alike
  AST_HOLD: assert property (NET_RX_DATA_ALARM_OUT && SYNC_EVENT_IN && !ALARM_CLEAR_IN && !PARAM_WR_IN
    |=> NET_RX_DATA_ALARM_OUT && $stable(SYNC_ERR_COUNT_OUT)) else $error("counter moved while alarmed");
  AST_RISE: assert property ($rose(NET_RX_DATA_ALARM_OUT)
    |-> $past(SYNC_EVENT_IN && !PDO_UPDATED_IN) && SYNC_ERR_COUNT_OUT != 16'h0000)
    else $error("receive alarm without a missed update");

  // ------------------------------------------------------------
  // Cycle selection, masks and mapping select
  // ------------------------------------------------------------
  AST_AUTO: assert property (PARAM_WR_IN && PARAM_SEL_IN == `NSS_SEL_CYCLE_INIT
    && PARAM_WDATA_IN[7:0] == `NSS_CODE_AUTO ##1 !PARAM_WR_IN |=> OUT_CYCLE_TIME_OUT == `NSS_NS_AUTO
    && IN_CYCLE_TIME_OUT == `NSS_NS_AUTO && !PARAM_ERROR_ALARM_OUT) else $error("automatic cycle wrong");
  AST_BADCODE: assert property (PARAM_WR_IN && PARAM_SEL_IN == `NSS_SEL_CYCLE_INIT
    && PARAM_WDATA_IN[7:0] == 8'h03 ##1 !PARAM_WR_IN |=> PARAM_ERROR_ALARM_OUT) else $error("no parameter alarm");
  AST_WMASK: assert property (PARAM_WR_IN && (PARAM_SEL_IN == `NSS_SEL_WARN_MASK
    || PARAM_SEL_IN == `NSS_SEL_WARN_MASK_OBJ) ##1 !PARAM_WR_IN
    |=> WARN_ACTIVE_OUT == ($past(WARN_ACTIVE_IN) & $past(PARAM_WDATA_IN, 2))) else $error("warning mask wrong");
  AST_EMASK: assert property (PARAM_WR_IN && (PARAM_SEL_IN == `NSS_SEL_ERR_MASK
    || PARAM_SEL_IN == `NSS_SEL_ERR_MASK_OBJ) ##1 !PARAM_WR_IN
    |=> ERR_LATCHED_OUT == ($past(ERR_LATCHED_IN) & $past(PARAM_WDATA_IN, 2))) else $error("error mask wrong");
  AST_MAP: assert property ((RX_MAP_ALLOW_OUT == `NSS_MAP_NEW_RX && TX_MAP_ALLOW_OUT == `NSS_MAP_NEW_TX)
    || (RX_MAP_ALLOW_OUT == `NSS_MAP_OLD_RX && TX_MAP_ALLOW_OUT == `NSS_MAP_OLD_TX)) else $error("bad mapping set");
endmodule

bind nss_top nss_sync_chk chk_u (
  .CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .PARAM_WR_IN(PARAM_WR_IN), .PARAM_SEL_IN(PARAM_SEL_IN),
  .PARAM_WDATA_IN(PARAM_WDATA_IN), .SYNC_EVENT_IN(SYNC_EVENT_IN), .PDO_UPDATED_IN(PDO_UPDATED_IN),
  .ALARM_CLEAR_IN(ALARM_CLEAR_IN), .WARN_ACTIVE_IN(WARN_ACTIVE_IN), .WARN_ACTIVE_OUT(WARN_ACTIVE_OUT),
  .ERR_LATCHED_IN(ERR_LATCHED_IN), .ERR_LATCHED_OUT(ERR_LATCHED_OUT), .OUT_CYCLE_TIME_OUT(OUT_CYCLE_TIME_OUT),
  .IN_CYCLE_TIME_OUT(IN_CYCLE_TIME_OUT), .PARAM_ERROR_ALARM_OUT(PARAM_ERROR_ALARM_OUT),
  .NET_RX_DATA_ALARM_OUT(NET_RX_DATA_ALARM_OUT), .SYNC_ERR_COUNT_OUT(SYNC_ERR_COUNT_OUT),
  .RX_MAP_ALLOW_OUT(RX_MAP_ALLOW_OUT), .TX_MAP_ALLOW_OUT(TX_MAP_ALLOW_OUT)
);

// ### bench/nss_master_model.sv
// Fieldbus master stand-in issuing sync events with or without updates.
// Assumes the bench clock; drives only on falling edges.
`timescale 1ns/1ps

module nss_master_model (
  input wire clk_in,
  output reg sync_evt_out,
  output reg pdo_upd_out
);
  // ------------------------------------------------------------
  // Idle level
  // ------------------------------------------------------------
  // Asynchronous master: never writes the cycle objects itself
  initial begin
    sync_evt_out = 1'b0;
    pdo_upd_out = 1'b1;
  end

  // One sync event, then an idle gap; the update flag flips after
  // the event so a design that samples it late is caught
  task send(input logic good, input int gap);
    @(negedge clk_in);
    sync_evt_out = 1'b1;
    pdo_upd_out = good;
    @(negedge clk_in);
    sync_evt_out = 1'b0;
    pdo_upd_out = ~good;
    repeat (gap) @(negedge clk_in);
  endtask
endmodule

// ### bench/network_sync_supervision_tb.sv
// Self-checking bench: register port, cycle selection, sync error
// counting, masks and mapping select. Assumes the master model beside it.
`timescale 1ns/1ps
`include "nss_consts.vh"

module network_sync_supervision_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic clr = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] wa = 32'hFFFFFFFF;
  logic [31:0] wl = 32'h12345678;
  logic [31:0] ea = 32'hFFFFFFFF;
  logic [31:0] el = 32'h87654321;
  wire [31:0] rdata, wa_o, wl_o, ea_o, el_o, ocyc, icyc;
  wire perr, rxal, sync_e, pdo_u;
  wire [15:0] cnt;
  wire [4:0] rxm, txm;
  int err_count = 0;
  int n_tests = 0;
  logic [31:0] rst_tab [12] = '{32'h0, 32'h0, 32'h9, 32'h0FFFFFFF, 32'h0FFFFFFF, 32'd250000, 32'd250000,
    32'h9, 32'h0FFFFFFF, 32'h0FFFFFFF, 32'h0, 32'h0};
  logic [7:0] codes [10] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h03, 8'h0B, 8'h00};
  logic [31:0] cyc_tab [10] = '{32'd125000, 32'd250000, 32'd500000, 32'd1000000, 32'd2000000,
    32'd4000000, 32'd8000000, 32'd8000000, 32'd8000000, 32'd250000};
  logic [15:0] walk [10] = '{16'd3, 16'd2, 16'd5, 16'd4, 16'd7, 16'd6, 16'd9, 16'd9, 16'd9, 16'd9};

  // ------------------------------------------------------------
  // Clock, design and far-side master
  // ------------------------------------------------------------
  always #20 clk = ~clk;

  nss_top dut_u (.CLK_IN(clk), .RST_B_IN(rst_b), .PARAM_WR_IN(wr), .PARAM_SEL_IN(sel), .PARAM_WDATA_IN(wdata),
    .PARAM_RDATA_OUT(rdata), .SYNC_EVENT_IN(sync_e), .PDO_UPDATED_IN(pdo_u), .ALARM_CLEAR_IN(clr),
    .WARN_ACTIVE_IN(wa), .WARN_LATCHED_IN(wl), .ERR_ACTIVE_IN(ea), .ERR_LATCHED_IN(el), .WARN_ACTIVE_OUT(wa_o),
    .WARN_LATCHED_OUT(wl_o), .ERR_ACTIVE_OUT(ea_o), .ERR_LATCHED_OUT(el_o), .OUT_CYCLE_TIME_OUT(ocyc),
    .IN_CYCLE_TIME_OUT(icyc), .PARAM_ERROR_ALARM_OUT(perr), .NET_RX_DATA_ALARM_OUT(rxal),
    .SYNC_ERR_COUNT_OUT(cnt), .RX_MAP_ALLOW_OUT(rxm), .TX_MAP_ALLOW_OUT(txm));
  nss_master_model master_u (.clk_in(clk), .sync_evt_out(sync_e), .pdo_upd_out(pdo_u));

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Write strobe lasts one cycle; an idle cycle always follows
  task wr_reg(input logic [3:0] s, input logic [31:0] d);
    @(negedge clk);
    wr = 1'b1;
    sel = s;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // Readback is registered, so it is taken one cycle after the select
  task rchk(input logic [3:0] s, input logic [31:0] e);
    @(negedge clk);
    sel = s;
    @(negedge clk);
    chk($sformatf("readback sel %h", s), e, rdata);
  endtask
  task syn(input logic good, input logic [15:0] ec, input logic ea_x);
    master_u.send(good, 0);
    chk("error count", {16'h0, ec}, {16'h0, cnt});
    chk("receive alarm", {31'h0, ea_x}, {31'h0, rxal});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Watchdog: whole sequence needs well under 1000 cycles
  // ------------------------------------------------------------
  initial begin
    #(40 * 4000);
    err_count++;
    finish_test;
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    for (int i = 0; i < 12; i++) rchk(i[3:0], rst_tab[i]);
    chk("map default", {22'h0, `NSS_MAP_NEW_RX, `NSS_MAP_NEW_TX}, {22'h0, rxm, txm});
    chk("warn default", wa & `NSS_RST_MASK, wa_o);
    $display("test reset values done");
    // Period codes, then unsupported ones that must leave the objects alone, then auto
    for (int i = 0; i < 10; i++) begin
      wr_reg(`NSS_SEL_CYCLE_INIT, {24'h0, codes[i]});
      repeat (2) @(negedge clk);
      chk("out cycle", cyc_tab[i], ocyc);
      chk("in cycle", cyc_tab[i], icyc);
      chk("param alarm", {31'h0, i == 7 || i == 8}, {31'h0, perr});
    end
    chk("auto cycle", `NSS_NS_AUTO, icyc);
    // Master-side object write is kept once no reload is pending
    wr_reg(`NSS_SEL_OUT_CYCLE_OBJ, 32'd500000);
    rchk(`NSS_SEL_OUT_CYCLE_OBJ, 32'd500000);
    $display("test cycle select done");
    // Alternating misses and good updates up to and past the alarm
    for (int i = 0; i < 10; i++) syn(i[0], walk[i], i > 5);
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    syn(1'b1, 16'h0, 1'b0);
    wr_reg(`NSS_SEL_LIMIT_OBJ, 32'h0);
    rchk(`NSS_SEL_SYNC_THR, 32'h0);
    repeat (4) syn(1'b0, 16'h0, 1'b0);
    wr_reg(`NSS_SEL_SYNC_THR, 32'h0000FFFF);
    rchk(`NSS_SEL_LIMIT_OBJ, 32'h00007FFF);
    wr_reg(`NSS_SEL_SYNC_THR, 32'h4);
    syn(1'b0, 16'h3, 1'b0);
    syn(1'b0, 16'h4, 1'b1);
    syn(1'b1, 16'h4, 1'b1);
    $display("test sync supervision done");
    wr_reg(`NSS_SEL_WARN_MASK_OBJ, 32'h0F0F00F0);
    wr_reg(`NSS_SEL_ERR_MASK, 32'h0A0A0A0A);
    repeat (2) @(negedge clk);
    chk("warn active", wa & 32'h0F0F00F0, wa_o);
    chk("warn latched", wl & 32'h0F0F00F0, wl_o);
    chk("err active", ea & 32'h0A0A0A0A, ea_o);
    chk("err latched", el & 32'h0A0A0A0A, el_o);
    rchk(`NSS_SEL_ERR_MASK_OBJ, 32'h0A0A0A0A);
    $display("test masks done");
    wr_reg(`NSS_SEL_MODE_WORD, 32'h00001000);
    repeat (2) @(negedge clk);
    chk("map legacy", {22'h0, `NSS_MAP_OLD_RX, `NSS_MAP_OLD_TX}, {22'h0, rxm, txm});
    wr_reg(`NSS_SEL_MODE_WORD, 32'h0);
    repeat (2) @(negedge clk);
    chk("map current", {22'h0, `NSS_MAP_NEW_RX, `NSS_MAP_NEW_TX}, {22'h0, rxm, txm});
    $display("test mapping select done");
    finish_test;
  end
endmodule
